// *** rtl/lpci_params.svh ***
// Constants for the light and proximity configuration and interrupt block
`ifndef LPCI_PARAMS_SVH
`define LPCI_PARAMS_SVH
`define LPCI_ADDR_ID 8'h00
`define LPCI_ADDR_CONFIG 8'h01
`define LPCI_ADDR_INTR 8'h02
`define LPCI_CONFIG_RESET 8'h00
`define LPCI_INTR_RESET 8'h00
`define LPCI_ID_DEFAULT 8'h5a
`define LPCI_CLK_PERIOD_NS 25
`define LPCI_CONV_TIME_NS 540000
`define LPCI_SLEEP_UNIT_NS 12500000
`define LPCI_SLEEP_800 8'h40
`define LPCI_SLEEP_400 8'h20
`define LPCI_SLEEP_200 8'h10
`define LPCI_SLEEP_100 8'h08
`define LPCI_SLEEP_75 8'h06
`define LPCI_SLEEP_50 8'h04
`define LPCI_SLEEP_12P5 8'h01
`define LPCI_SLEEP_NONE 8'h00
`define LPCI_PERSIST_1 5'h01
`define LPCI_PERSIST_4 5'h04
`define LPCI_PERSIST_8 5'h08
`define LPCI_PERSIST_16 5'h10
`endif

// *** rtl/lpci_persist.sv ***
// Consecutive out-of-window counter for one interrupt condition
`timescale 1ns/100ps
module lpci_persist
  import lpci_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic outside,
  input wire logic [1:0] count_sel,
  output logic reached
);
  logic [4:0] count;
  logic [4:0] next_count;
  logic [5:0] count_plus;
  logic [4:0] target;

  assign target = lpci_persist_target(count_sel);
  assign count_plus = {1'b0, count} + 6'h01;
  // Saturate at the target so a long run keeps re-setting, never wraps
  assign next_count = !sample_valid ? count :
                      !outside ? 5'h00 :
                      (count >= target) ? count : count_plus[4:0];
  assign reached = sample_valid && outside && (count_plus >= {1'b0, target});

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= 5'h00;
    end else begin
      count <= next_count;
    end
  end
endmodule : lpci_persist

// *** rtl/lpci_pkg.sv ***
// Types and shared decoding for the light and proximity control block
`include "lpci_params.svh"
package lpci_pkg;
  typedef struct packed {
    logic near_enable;
    logic [2:0] sleep_code;
    logic led_drive_strength;
    logic light_sense_enable;
    logic light_full_scale_select;
    logic light_source_select;
  } lpci_config_type;

  typedef struct packed {
    logic near_flag;
    logic [1:0] near_persistence;
    logic zero_bit;
    logic light_window_flag;
    logic [1:0] light_persistence;
    logic combine_and;
  } lpci_intr_type;

  typedef enum logic [1:0] {
    LPCI_IDLE = 2'b00,
    LPCI_CONVERT = 2'b01,
    LPCI_SLEEP = 2'b11
  } lpci_state_type;

  function automatic logic [4:0] lpci_persist_target(input logic [1:0] sel);
    case (sel)
      2'b00: lpci_persist_target = `LPCI_PERSIST_1;
      2'b01: lpci_persist_target = `LPCI_PERSIST_4;
      2'b10: lpci_persist_target = `LPCI_PERSIST_8;
      default: lpci_persist_target = `LPCI_PERSIST_16;
    endcase
  endfunction : lpci_persist_target
endpackage : lpci_pkg

// *** rtl/lpci_top.sv ***
// Configuration, proximity sequencing and interrupt flags of the sensor
`timescale 1ns/100ps
`include "lpci_params.svh"
module lpci_top
  import lpci_pkg::*;
#(
  parameter logic [7:0] ID_CODE = `LPCI_ID_DEFAULT, // Arbitrary value
  parameter int CONV_CYCLES = `LPCI_CONV_TIME_NS / `LPCI_CLK_PERIOD_NS,
  parameter int SLEEP_UNIT_CYCLES = `LPCI_SLEEP_UNIT_NS / `LPCI_CLK_PERIOD_NS
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic light_result_valid,
  input wire logic [11:0] light_result,
  input wire logic [11:0] light_lower_threshold,
  input wire logic [11:0] light_upper_threshold,
  input wire logic near_result_valid,
  input wire logic [7:0] near_result,
  input wire logic [7:0] near_lower_threshold,
  input wire logic [7:0] near_upper_threshold,
  output lpci_config_type sensing_config,
  output logic light_convert_enable,
  output logic near_convert,
  output logic int_pin_out,
  output logic int_pin_oe
);
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  lpci_config_type config_q;
  lpci_intr_type intr_q;
  lpci_intr_type next_intr;
  logic [7:0] next_rdata;
  logic wr_config;
  logic wr_intr;

  assign wr_config = reg_write && (reg_addr == `LPCI_ADDR_CONFIG);
  assign wr_intr = reg_write && (reg_addr == `LPCI_ADDR_INTR);
  // Writes to the identification address are dropped
  assign next_rdata = (reg_addr == `LPCI_ADDR_ID) ? ID_CODE :
                      (reg_addr == `LPCI_ADDR_CONFIG) ? config_q :
                      (reg_addr == `LPCI_ADDR_INTR) ? intr_q : 8'h00;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      config_q <= `LPCI_CONFIG_RESET;
    end else if (wr_config) begin
      config_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // Source, range and drive fields go straight to the analog side
  assign sensing_config = config_q;
  assign light_convert_enable = config_q.light_sense_enable;

  // ----------------------------------------------------------------
  // Proximity sequencer
  // ----------------------------------------------------------------
  lpci_state_type state;
  lpci_state_type next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [31:0] sleep_cycles;
  logic timer_done;

  function automatic logic [7:0] sleep_units(input logic [2:0] code);
    case (code)
      3'h0: sleep_units = `LPCI_SLEEP_800;
      3'h1: sleep_units = `LPCI_SLEEP_400;
      3'h2: sleep_units = `LPCI_SLEEP_200;
      3'h3: sleep_units = `LPCI_SLEEP_100;
      3'h4: sleep_units = `LPCI_SLEEP_75;
      3'h5: sleep_units = `LPCI_SLEEP_50;
      3'h6: sleep_units = `LPCI_SLEEP_12P5;
      default: sleep_units = `LPCI_SLEEP_NONE;
    endcase
  endfunction : sleep_units

  // Product fits 32 bits for every code at the default unit
  assign sleep_cycles = 32'(sleep_units(config_q.sleep_code)) * 32'(SLEEP_UNIT_CYCLES);
  assign timer_done = (timer <= 32'h1);

  always_comb begin
    next_state = state;
    next_timer = timer - 32'h1;
    if (!config_q.near_enable) begin
      next_state = LPCI_IDLE;
      next_timer = 32'h0;
    end else begin
      unique case (state)
        LPCI_IDLE: begin
          next_state = LPCI_CONVERT;
          next_timer = 32'(CONV_CYCLES);
        end
        LPCI_CONVERT: begin
          if (timer_done) begin
            // Sleep code 7 skips straight to the next conversion
            if (sleep_cycles == 32'h0) begin
              next_timer = 32'(CONV_CYCLES);
            end else begin
              next_state = LPCI_SLEEP;
              next_timer = sleep_cycles;
            end
          end
        end
        LPCI_SLEEP: begin
          if (timer_done) begin
            next_state = LPCI_CONVERT;
            next_timer = 32'(CONV_CYCLES);
          end
        end
        default: begin
          next_state = LPCI_IDLE;
          next_timer = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= LPCI_IDLE;
      timer <= 32'h0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  assign near_convert = (state == LPCI_CONVERT);

  // ----------------------------------------------------------------
  // Persistence and flags
  // ----------------------------------------------------------------
  logic light_outside;
  logic light_valid;
  logic near_valid;
  logic near_high;
  logic near_low;
  logic light_set;
  logic near_set;
  logic near_clear;

  assign light_valid = light_result_valid && config_q.light_sense_enable;
  assign near_valid = near_result_valid && config_q.near_enable;
  assign light_outside = (light_result <= light_lower_threshold) ||
                         (light_result >= light_upper_threshold);
  assign near_high = near_result >= near_upper_threshold;
  assign near_low = near_result <= near_lower_threshold;

  lpci_persist light_run (
    .clock(clock),
    .rst(rst),
    .sample_valid(light_valid),
    .outside(light_outside),
    .count_sel(intr_q.light_persistence),
    .reached(light_set)
  );

  lpci_persist near_up_run (
    .clock(clock),
    .rst(rst),
    .sample_valid(near_valid),
    .outside(near_high),
    .count_sel(intr_q.near_persistence),
    .reached(near_set)
  );

  lpci_persist near_down_run (
    .clock(clock),
    .rst(rst),
    .sample_valid(near_valid),
    .outside(near_low),
    .count_sel(intr_q.near_persistence),
    .reached(near_clear)
  );

  // A set in the same cycle as a clearing write wins
  always_comb begin
    next_intr = intr_q;
    if (wr_intr) begin
      next_intr = reg_wdata;
      next_intr.near_flag = intr_q.near_flag && reg_wdata[7];
      next_intr.light_window_flag = intr_q.light_window_flag && reg_wdata[3];
    end
    next_intr.zero_bit = 1'b0;
    if (near_clear) begin
      next_intr.near_flag = 1'b0;
    end
    if (near_set) begin
      next_intr.near_flag = 1'b1;
    end
    if (light_set) begin
      next_intr.light_window_flag = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intr_q <= `LPCI_INTR_RESET;
    end else begin
      intr_q <= next_intr;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  logic int_active;

  assign int_active = intr_q.combine_and ?
                      (intr_q.near_flag && intr_q.light_window_flag) :
                      (intr_q.near_flag || intr_q.light_window_flag);

  // Registered so the pin never glitches from decode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_pin_oe <= 1'b0;
    end else begin
      int_pin_oe <= int_active;
    end
  end

  assign int_pin_out = 1'b0; // Open drain only ever pulls low
endmodule : lpci_top

// *** verif/lpci_bench.sv ***
// Self-checking bench for the control block
`timescale 1ns/100ps
module lpci_bench;
  import lpci_pkg::*;
  logic clock, rst, reg_write, reg_read, light_result_valid, near_result_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, near_result, d;
  logic [7:0] near_lower_threshold, near_upper_threshold;
  logic [11:0] light_result, light_lower_threshold, light_upper_threshold;
  lpci_config_type sensing_config;
  logic light_convert_enable, near_convert, int_pin_out, int_pin_oe;
  int n_fail = 0;
  int cmp_count = 0;
  lpci_top #(.CONV_CYCLES(6), .SLEEP_UNIT_CYCLES(4)) dut (.*);
  lpci_host host (.*);
  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic pulse(input logic near, input logic [11:0] v, input int n);
    repeat (n) begin
      @(negedge clock);
      light_result = v;
      near_result = v[7:0];
      light_result_valid = !near;
      near_result_valid = near;
    end
    @(negedge clock);
    light_result_valid = 1'b0;
    near_result_valid = 1'b0;
    light_result = ~v;
    near_result = ~v[7:0];
  endtask : pulse
  task automatic t_idle;
    host.get(8'h01, d);
    chk("config reset", d, 8'h00);
    pulse(1'b0, 12'h0c8, 1);
    host.get(8'h02, d);
    chk("intr reset", d, 8'h00);
    host.get(8'h05, d);
    chk("unmapped", d, 8'h00);
  endtask : t_idle
  task automatic t_config;
    for (int i = 0; i < 8; i++) begin
      host.put(8'h01, 8'h01 << i);
      host.get(8'h01, d);
      chk("config", d, 8'h01 << i);
      chk("config port", sensing_config, 8'h01 << i);
      chk("light enable", light_convert_enable, i == 2);
    end
  endtask : t_config
  task automatic t_light;
    int n[4] = '{1, 4, 8, 16};
    host.put(8'h01, 8'h04);
    for (int p = 0; p < 4; p++) begin
      host.put(8'h02, 8'(p << 1));
      // Inside result first, so a run left over from the last field starts afresh
      pulse(1'b0, 12'h096, 1);
      pulse(1'b0, 12'h0c8, n[p] - 1);
      pulse(1'b0, 12'h096, 1);
      pulse(1'b0, 12'h0c8, n[p] - 1);
      host.get(8'h02, d);
      chk("light early", d, 8'(p << 1));
      pulse(1'b0, 12'h064, 1);
      host.get(8'h02, d);
      chk("light flag", d, 8'(p << 1) | 8'h08);
      chk("pin or", int_pin_oe, 1'b1);
      host.put(8'h02, 8'h00);
      @(negedge clock);
      chk("pin clear", int_pin_oe, 1'b0);
    end
  endtask : t_light
  task automatic t_near;
    host.put(8'h01, 8'h84);
    host.put(8'h02, 8'h20);
    pulse(1'b1, 12'h050, 3);
    pulse(1'b1, 12'h030, 1);
    pulse(1'b1, 12'h050, 4);
    host.get(8'h02, d);
    chk("near flag", d, 8'ha0);
    host.put(8'h02, 8'ha1);
    @(negedge clock);
    chk("pin and one", int_pin_oe, 1'b0);
    pulse(1'b0, 12'h064, 1);
    @(negedge clock);
    chk("pin and both", int_pin_oe, 1'b1);
    pulse(1'b1, 12'h014, 4);
    host.get(8'h02, d);
    chk("near clear", d, 8'h29);
    chk("pin released", int_pin_oe, 1'b0);
    host.put(8'h02, 8'h00);
  endtask : t_near
  task automatic wait_conv(input logic lv);
    for (int k = 0; k < 400 && near_convert !== lv; k++) @(negedge clock);
  endtask : wait_conv
  // Code 7 has no sleep gap, so conversion must simply stay on
  task automatic t_sleep;
    int units[8] = '{64, 32, 16, 8, 6, 4, 1, 0};
    int gap;
    for (int c = 0; c < 8; c++) begin
      host.put(8'h01, 8'h80 | 8'(c << 4));
      wait_conv(1'b1);
      wait_conv(1'b0);
      for (gap = 0; gap < 300 && near_convert === 1'b0; gap++) @(negedge clock);
      if (c < 7) chk("sleep gap", 12'(gap), 12'(units[c] * 4));
      else chk("no sleep", near_convert, 1'b1);
    end
    host.put(8'h01, 8'h00);
  endtask : t_sleep
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    light_result_valid = 1'b0;
    near_result_valid = 1'b0;
    light_result = 12'h000;
    near_result = 8'h00;
    light_lower_threshold = 12'h064;
    light_upper_threshold = 12'h0c8;
    near_lower_threshold = 8'h14;
    near_upper_threshold = 8'h50;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_idle;
    t_config;
    t_light;
    t_near;
    t_sleep;
    give_verdict;
  end
  initial begin
    #(25 * 20000);
    n_fail++;
    give_verdict;
  end
endmodule : lpci_bench
bind lpci_top lpci_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

// *** verif/lpci_chk.sv ***
// Port assertions for the control block
`timescale 1ns/100ps
module lpci_chk
  import lpci_pkg::*;
#(
  parameter int CONV_CYCLES = 20
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic light_result_valid,
  input wire logic near_result_valid,
  input wire lpci_config_type sensing_config,
  input wire logic light_convert_enable,
  input wire logic near_convert,
  input wire logic int_pin_out,
  input wire logic int_pin_oe
);
  // ----
  // Conversion length counter
  // ----
  logic [15:0] run;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) run <= 16'h0000;
    else run <= near_convert ? run + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_clr;
    reg_write && reg_addr == 8'h02 && reg_wdata == 8'h00;
  endsequence
  sequence s_quiet;
    !light_result_valid && !near_result_valid;
  endsequence
  // A result in the clearing cycle wins, so only quiet clears count
  property p_clr;
    s_clr and s_quiet |-> ##2 !int_pin_oe;
  endproperty
  a_clr: assert property (p_clr) else $error("pin held after flag clear");
  property p_rst;
    $fell(rst) |-> sensing_config == 8'h00 && !int_pin_oe && !near_convert;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_wr;
    reg_write && reg_addr == 8'h01 |=> sensing_config == $past(reg_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("config write lost");
  property p_len;
    light_convert_enable == sensing_config.light_sense_enable;
  endproperty
  a_len: assert property (p_len) else $error("light enable mismatch");
  property p_rd;
    reg_read && reg_addr == 8'h01 |=> reg_rdata == $past(sensing_config);
  endproperty
  a_rd: assert property (p_rd) else $error("config read wrong");
  property p_b4;
    reg_read && reg_addr == 8'h02 |=> !reg_rdata[4];
  endproperty
  a_b4: assert property (p_b4) else $error("bit 4 not zero");
  property p_od;
    int_pin_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_off;
    (!sensing_config.near_enable)[*2] |-> !near_convert;
  endproperty
  a_off: assert property (p_off) else $error("converts while off");
  property p_conv;
    $fell(near_convert) && sensing_config.near_enable |-> run == CONV_CYCLES;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
endmodule : lpci_chk

// *** verif/lpci_host.sv ***
// Host model on the register port
`timescale 1ns/100ps
module lpci_host (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial begin
    reg_addr = 8'h01;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Never addresses the identification byte; clears flags with zeros
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask : get
endmodule : lpci_host
